//--- rtl/ssu_i2c_master.sv
// Second serial unit: two-wire master and SPI master sharing one-byte FIFOs.
// Assumes a synchronous register port and open-drain pads resolved outside.
`timescale 1ns/1ps
`include "ssu_consts.svh"

module ssu_i2c_master (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire ssu_pkg::ssu_req_s req_i,
  output logic [15:0]           rdata_o,
  input  wire logic             top_irq_en_i,
  output logic                  irq_o,
  output ssu_pkg::ssu_evt_s     evt_o,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe_o,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  output logic                  spi_sck_o,
  output logic                  spi_mosi_o,
  input  wire logic             spi_miso_i
);
  import ssu_pkg::*;

  // Address match used by every strobe and write decode below; the read data mux uses a case instead.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  // Bit presented next on the wire for the chosen order.
  function automatic logic out_bit(input logic [7:0] b, input logic msb);
    return msb ? b[7] : b[0];
  endfunction

  // Shift out the presented bit.
  function automatic logic [7:0] shift_out(input logic [7:0] b, input logic msb);
    return msb ? {b[6:0], 1'b0} : {1'b0, b[7:1]};
  endfunction

  // Shift one sampled bit into a receive byte.
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic v,
                                          input logic msb);
    return msb ? {b[6:0], v} : {v, b[7:1]};
  endfunction

  // Software registers.
  ssu_mode_e   mode_q;    // Operating mode.
  logic [5:0]  spicfg_q;  // SPI framing bits.
  logic [3:0]  lin_q;     // Linear rate term.
  logic [3:0]  exp_q;     // Power-of-two rate term.
  logic        ackc_q;    // Acknowledge control for received bytes.
  logic [5:0]  imask_q;   // Unit interrupt mask, one bit per event.
  logic [3:0]  cmd_q;     // Pending bus commands.
  logic [3:0]  stat_q;    // Status flags, laid out as read.
  logic [15:0] rdata_q;   // Read data, valid the cycle after the strobe.

  // One-byte FIFOs.
  logic        tx_full_q; // Transmit byte present.
  logic [7:0]  tx_byte_q; // Transmit byte.
  logic        rx_full_q; // Receive byte present.
  logic [7:0]  rx_byte_q; // Receive byte.

  // Segment engine.
  ssu_state_e  state_q;   // Current segment.
  logic [1:0]  step_q;    // Phase inside a condition or a bit slot.
  logic [3:0]  cnt_q;     // Bit slot or SPI edge index.
  logic [7:0]  sh_q;      // Outgoing shift register.
  logic [7:0]  rsh_q;     // Incoming shift register.
  logic        snd_q;     // Byte segment is a send.
  logic        scl_low_q; // Pull the clock line low.
  logic        sda_low_q; // Pull the data line low.
  logic        sck_q;     // SPI clock level.
  logic        mosi_q;    // SPI data out.

  // Pin synchronisers; only the second stage is read by logic.
  logic scl_s1_q, scl_s2_q;
  logic sda_s1_q, sda_s2_q;
  logic miso_s1_q, miso_s2_q;

  // Events and interrupt.
  ssu_evt_s evt_d, evt_q;
  logic     irq_q;

  // Engine strobes and helpers.
  logic       tick;       // Half-period tick from the divider.
  logic       adv;        // Engine takes a step this cycle.
  logic       fin;        // Segment completes this cycle.
  logic       go_twi;     // Launch a two-wire segment.
  logic       go_spi;     // Launch an SPI byte.
  logic       abort;      // Mode no longer matches the running segment.
  logic       tx_pop;     // Launch takes the transmit byte.
  logic       rx_push;    // Completed receive delivers a byte.
  logic [7:0] rx_in;      // Byte delivered to the receive FIFO.
  logic [7:0] rsh_nx;     // Incoming shift after this step.
  logic       sample;     // This SPI edge samples.
  logic [3:0] cmd_clr;    // Command bit finished this cycle.
  logic [3:0] stat_d;     // Next status flags.
  logic       wr_data, rd_data, wr_cmd;

  // Register port decode.
  always_comb begin
    wr_data = req_i.wr && hit(req_i.addr, `SSU_DATA_OFF);
    rd_data = req_i.rd && hit(req_i.addr, `SSU_DATA_OFF);
    wr_cmd  = req_i.wr && hit(req_i.addr, `SSU_CMD_OFF);
  end

  // Bring the pads into the clock domain before anything looks at them.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_s1_q  <= 1'b1;
      scl_s2_q  <= 1'b1;
      sda_s1_q  <= 1'b1;
      sda_s2_q  <= 1'b1;
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      scl_s1_q  <= scl_i;
      scl_s2_q  <= scl_s1_q;
      sda_s1_q  <= sda_i;
      sda_s2_q  <= sda_s1_q;
      miso_s1_q <= spi_miso_i;
      miso_s2_q <= miso_s1_q;
    end
  end

  // Serial clock divider; it only runs while a segment is in flight.
  ssu_rate_tick u_tick (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .run_i     (state_q != SSU_IDLE),
    .lin_i     (lin_q),
    .exp_i     (exp_q),
    .tick_o    (tick)
  );

  // Launch, step and completion strobes of the engine.
  always_comb begin
    // Modes 0 and 1 leave the engine idle; 2 and 3 pick the engine.
    go_twi = (state_q == SSU_IDLE) && (mode_q == SSU_TWI) && (cmd_q != 4'h0);
    // Start trigger: transmit data present, or receive space when set.
    go_spi = (state_q == SSU_IDLE) && (mode_q == SSU_SPI) &&
             (spicfg_q[`SSU_SPI_RXDRV] ? !rx_full_q : tx_full_q);
    abort  = ((state_q == SSU_SHIFT) && (mode_q != SSU_SPI)) ||
             ((state_q != SSU_SHIFT) && (state_q != SSU_IDLE) && (mode_q != SSU_TWI));
    // A released clock line still held low by a slave stretches the step.
    adv    = tick && !abort && ((state_q == SSU_SHIFT) || scl_low_q || scl_s2_q);
    // Sample on the leading edge when phase is clear, else the second.
    sample = (~cnt_q[0]) ^ spicfg_q[`SSU_SPI_PHA];
    rsh_nx = rsh_q;
    fin    = 1'b0;
    case (state_q)
      SSU_START: fin = adv && (step_q == 2'h2);
      SSU_STOP:  fin = adv && (step_q == 2'h1);
      SSU_BYTE: begin
        fin = adv && (step_q == 2'h1) && (cnt_q == `SSU_TWI_LAST);
        if (adv && (step_q == 2'h1) && (cnt_q != `SSU_TWI_LAST)) begin
          rsh_nx = shift_in(rsh_q, sda_s2_q, 1'b1);
        end
      end
      SSU_SHIFT: begin
        fin = adv && (cnt_q == `SSU_SPI_LAST);
        if (adv && sample) begin
          rsh_nx = shift_in(rsh_q, miso_s2_q, spicfg_q[`SSU_SPI_ORD]);
        end
      end
      default: fin = 1'b0;
    endcase
    tx_pop  = go_spi || (go_twi && !cmd_q[`SSU_CMD_START] && !cmd_q[`SSU_CMD_STOP] &&
                         cmd_q[`SSU_CMD_SEND]);
    rx_push = fin && ((state_q == SSU_SHIFT) || ((state_q == SSU_BYTE) && !snd_q));
    rx_in   = rsh_nx;
    cmd_clr = 4'h0;
    if (fin) begin
      case (state_q)
        SSU_START: cmd_clr[`SSU_CMD_START] = 1'b1;
        SSU_STOP:  cmd_clr[`SSU_CMD_STOP]  = 1'b1;
        SSU_BYTE:  cmd_clr = snd_q ? 4'h2 : 4'h1;
        default:   cmd_clr = 4'h0;
      endcase
    end
  end

  // Segment engine. Priority when several bits are pending: start, stop, send, receive.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q   <= SSU_IDLE;
      step_q    <= 2'h0;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      rsh_q     <= 8'h00;
      snd_q     <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      sck_q     <= 1'b0;
      mosi_q    <= 1'b0;
    end else if (abort) begin
      // Leaving an active mode mid-segment releases the wires at once.
      state_q   <= SSU_IDLE;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (go_twi) begin
      step_q <= 2'h0;
      cnt_q  <= 4'h0;
      if (cmd_q[`SSU_CMD_START]) begin
        state_q   <= SSU_START;
        sda_low_q <= 1'b0;
      end else if (cmd_q[`SSU_CMD_STOP]) begin
        state_q   <= SSU_STOP;
        sda_low_q <= 1'b1;
      end else if (cmd_q[`SSU_CMD_SEND]) begin
        // An empty FIFO sends the idle filler.
        state_q   <= SSU_BYTE;
        snd_q     <= 1'b1;
        sh_q      <= tx_full_q ? shift_out(tx_byte_q, 1'b1) : 8'hfe;
        sda_low_q <= tx_full_q ? !out_bit(tx_byte_q, 1'b1) : 1'b0;
      end else begin
        state_q   <= SSU_BYTE;
        snd_q     <= 1'b0;
        sda_low_q <= 1'b0;
      end
    end else if (go_spi) begin
      // Phase clear puts the first bit out before the leading edge.
      state_q <= SSU_SHIFT;
      cnt_q   <= 4'h0;
      sck_q   <= spicfg_q[`SSU_SPI_POL];
      if (!spicfg_q[`SSU_SPI_PHA]) begin
        mosi_q <= out_bit(tx_full_q ? tx_byte_q : `SSU_IDLE_BYTE, spicfg_q[`SSU_SPI_ORD]);
        sh_q   <= shift_out(tx_full_q ? tx_byte_q : `SSU_IDLE_BYTE, spicfg_q[`SSU_SPI_ORD]);
      end else begin
        sh_q <= tx_full_q ? tx_byte_q : `SSU_IDLE_BYTE;
      end
    end else if (adv) begin
      rsh_q <= rsh_nx;
      case (state_q)
        SSU_START: begin
          // Release clock, then pull data low with clock high, then clock low.
          step_q <= step_q + 2'h1;
          if (step_q == 2'h0) scl_low_q <= 1'b0;
          if (step_q == 2'h1) sda_low_q <= 1'b1;
          if (step_q == 2'h2) begin
            scl_low_q <= 1'b1;
            state_q   <= SSU_IDLE;
          end
        end
        SSU_STOP: begin
          // Release clock, then release data while clock is high.
          step_q <= step_q + 2'h1;
          if (step_q == 2'h0) scl_low_q <= 1'b0;
          if (step_q == 2'h1) begin
            sda_low_q <= 1'b0;
            state_q   <= SSU_IDLE;
          end
        end
        SSU_BYTE: begin
          if (step_q == 2'h0) begin
            scl_low_q <= 1'b0;
            step_q    <= 2'h1;
          end else begin
            scl_low_q <= 1'b1;
            step_q    <= 2'h0;
            cnt_q     <= cnt_q + 4'h1;
            if (cnt_q == `SSU_TWI_LAST) begin
              state_q   <= SSU_IDLE;
              sda_low_q <= 1'b0;
            end else if (cnt_q == 4'h7) begin
              // Ack slot: release for the slave, or answer per control bit.
              sda_low_q <= snd_q ? 1'b0 : ackc_q;
            end else begin
              sda_low_q <= snd_q ? !out_bit(sh_q, 1'b1) : 1'b0;
              sh_q      <= shift_out(sh_q, 1'b1);
            end
          end
        end
        SSU_SHIFT: begin
          // Each tick is one clock edge; the idle level follows polarity.
          sck_q <= !sck_q;
          cnt_q <= cnt_q + 4'h1;
          if (!sample) begin
            mosi_q <= out_bit(sh_q, spicfg_q[`SSU_SPI_ORD]);
            sh_q   <= shift_out(sh_q, spicfg_q[`SSU_SPI_ORD]);
          end
          if (cnt_q == `SSU_SPI_LAST) state_q <= SSU_IDLE;
        end
        default: state_q <= SSU_IDLE;
      endcase
    end else if (state_q == SSU_IDLE) begin
      // The idle clock rests at the polarity level, so a launch adds no stray edge.
      sck_q <= spicfg_q[`SSU_SPI_POL];
    end
  end

  // Transmit FIFO: a data write fills it, a launch empties it; a write in
  // the same cycle as the launch keeps the new byte.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_full_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else if (wr_data) begin
      tx_full_q <= 1'b1;
      tx_byte_q <= req_i.wdata[7:0];
    end else if (tx_pop) begin
      tx_full_q <= 1'b0;
    end
  end

  // Receive FIFO: a data read empties it, a finished byte fills it unless
  // it is still full, in which case the byte is lost.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_full_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else if (rx_push && (!rx_full_q || rd_data)) begin
      rx_full_q <= 1'b1;
      rx_byte_q <= rx_in;
    end else if (rd_data) begin
      rx_full_q <= 1'b0;
    end
  end

  // Command bits: software sets them in two-wire mode only, completion clears; a write that sets a bit
  // in its completion cycle wins. Writing zero has no effect.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_q <= 4'h0;
    end else if (wr_cmd && (mode_q == SSU_TWI)) begin
      cmd_q <= (cmd_q & ~cmd_clr) | req_i.wdata[3:0];
    end else begin
      cmd_q <= cmd_q & ~cmd_clr;
    end
  end

  // Status flags: cleared when the next two-wire segment starts, set at its completion; SPI bytes leave them alone.
  always_comb begin
    stat_d = go_twi ? 4'h0 : stat_q;
    if (fin && (state_q == SSU_START || state_q == SSU_STOP)) begin
      stat_d[`SSU_ST_CMDFIN] = 1'b1;
    end
    if (fin && (state_q == SSU_BYTE) && snd_q) begin
      stat_d[`SSU_ST_TXFIN] = 1'b1;
      stat_d[`SSU_ST_NACK]  = sda_s2_q;
    end
    if (fin && (state_q == SSU_BYTE) && !snd_q) begin
      stat_d[`SSU_ST_RXFIN] = 1'b1;
    end
  end

  // Event pulses from flag rises and FIFO faults.
  always_comb begin
    evt_d.cmd_done = stat_d[`SSU_ST_CMDFIN] && !stat_q[`SSU_ST_CMDFIN];
    evt_d.tx_done  = stat_d[`SSU_ST_TXFIN] && !stat_q[`SSU_ST_TXFIN];
    evt_d.tx_nack  = evt_d.tx_done && stat_d[`SSU_ST_NACK];
    evt_d.rx_done  = stat_d[`SSU_ST_RXFIN] && !stat_q[`SSU_ST_RXFIN];
    evt_d.rx_ovf   = rx_push && rx_full_q && !rd_data;
    evt_d.tx_unf   = tx_pop && !tx_full_q;
  end

  // Flags, events and the gated interrupt, one cycle after the cause.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= 4'h0;
      evt_q  <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      evt_q  <= evt_d;
      irq_q  <= top_irq_en_i && ((evt_d & imask_q) != 6'h00);
    end
  end

  // Configuration registers; reserved bits are not stored.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q   <= SSU_OFF0;
      spicfg_q <= 6'h00;
      lin_q    <= 4'h0;
      exp_q    <= 4'h0;
      ackc_q   <= 1'b0;
      imask_q  <= 6'h00;
    end else if (req_i.wr) begin
      if (hit(req_i.addr, `SSU_MODE_OFF)) mode_q <= ssu_mode_e'(req_i.wdata[1:0]);
      if (hit(req_i.addr, `SSU_SPICFG_OFF)) spicfg_q <= req_i.wdata[5:0];
      if (hit(req_i.addr, `SSU_RLIN_OFF)) lin_q <= req_i.wdata[3:0];
      if (hit(req_i.addr, `SSU_REXP_OFF)) exp_q <= req_i.wdata[3:0];
      if (hit(req_i.addr, `SSU_ACKC_OFF)) ackc_q <= req_i.wdata[`SSU_ACK_BIT];
      if (hit(req_i.addr, `SSU_IMASK_OFF)) imask_q <= req_i.wdata[5:0];
    end
  end

  // Read data for the cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= `SSU_REG_RST;
    end else if (req_i.rd) begin
      case (req_i.addr)
        `SSU_DATA_OFF:   rdata_q <= {8'h00, rx_byte_q};
        `SSU_STAT_OFF:   rdata_q <= {12'h000, stat_q};
        `SSU_CMD_OFF:    rdata_q <= {12'h000, cmd_q};
        `SSU_ACKC_OFF:   rdata_q <= {15'h0000, ackc_q};
        `SSU_MODE_OFF:   rdata_q <= {14'h0000, mode_q};
        `SSU_SPICFG_OFF: rdata_q <= {10'h000, spicfg_q};
        `SSU_RLIN_OFF:   rdata_q <= {12'h000, lin_q};
        `SSU_REXP_OFF:   rdata_q <= {12'h000, exp_q};
        `SSU_IMASK_OFF:  rdata_q <= {10'h000, imask_q};
        default:         rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Open-drain wires only ever pull low.
  assign scl_o      = 1'b0;
  assign scl_oe_o   = scl_low_q;
  assign sda_o      = 1'b0;
  assign sda_oe_o   = sda_low_q;
  assign spi_sck_o  = sck_q;
  assign spi_mosi_o = mosi_q;
  assign rdata_o    = rdata_q;
  assign evt_o      = evt_q;
  assign irq_o      = irq_q;

endmodule

//--- inc/ssu_consts.svh
// Offsets, field positions, reset values and timing figures of the second serial unit.
// Assumes a 16-bit register port addressed by the printed byte offsets.
`ifndef SSU_CONSTS_SVH
`define SSU_CONSTS_SVH

// Register offsets on the plain register port.
`define SSU_DATA_OFF    16'h441e
`define SSU_STAT_OFF    16'h4422
`define SSU_CMD_OFF     16'h4426
`define SSU_ACKC_OFF    16'h4428
`define SSU_MODE_OFF    16'h442a
`define SSU_SPICFG_OFF  16'h442c
`define SSU_RLIN_OFF    16'h4430
`define SSU_REXP_OFF    16'h4432
`define SSU_IMASK_OFF   16'h4440

// Bus command register fields.
`define SSU_CMD_RECV    0
`define SSU_CMD_SEND    1
`define SSU_CMD_START   2
`define SSU_CMD_STOP    3

// Bus status register fields.
`define SSU_ST_NACK     0
`define SSU_ST_TXFIN    1
`define SSU_ST_RXFIN    2
`define SSU_ST_CMDFIN   3

// SPI framing fields.
`define SSU_SPI_POL     0
`define SSU_SPI_PHA     1
`define SSU_SPI_ORD     2
`define SSU_SPI_RXDRV   5

// Acknowledge control field.
`define SSU_ACK_BIT     0

// Reset values and fillers.
`define SSU_REG_RST     16'h0000
`define SSU_IDLE_BYTE   8'hff

// Timing: divider base rate and the rate of the reference clock, in hertz.
`define SSU_BASE_HZ     24000000
`define SSU_REF_HZ      20000000

// Segment lengths: nine bit slots per two-wire byte, sixteen clock edges per SPI byte.
`define SSU_TWI_LAST    4'h8
`define SSU_SPI_LAST    4'hf

`endif

//--- inc/ssu_pkg.sv
// Types shared by the second serial unit design files.
// Assumes the constants header is included by any user of the offsets.
package ssu_pkg;

  // Operating mode selected by software.
  typedef enum logic [1:0] {
    SSU_OFF0 = 2'b00,
    SSU_OFF1 = 2'b01,
    SSU_SPI  = 2'b10,
    SSU_TWI  = 2'b11
  } ssu_mode_e;

  // Segment engine states.
  typedef enum logic [2:0] {
    SSU_IDLE  = 3'b000,
    SSU_START = 3'b001,
    SSU_STOP  = 3'b010,
    SSU_BYTE  = 3'b011,
    SSU_SHIFT = 3'b100
  } ssu_state_e;

  // One register port request.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ssu_req_s;

  // Event pulses, bit 0 is cmd_done.
  typedef struct packed {
    logic tx_unf;
    logic rx_ovf;
    logic rx_done;
    logic tx_done;
    logic tx_nack;
    logic cmd_done;
  } ssu_evt_s;

endpackage

//--- rtl/ssu_rate_tick.sv
// Half-period tick generator for the serial clock of the second serial unit.
// Assumes lin_i and exp_i come from registers on the same clock.
`timescale 1ns/1ps
`include "ssu_consts.svh"

module ssu_rate_tick #(
  parameter int unsigned BASE_HZ = `SSU_BASE_HZ,
  parameter int unsigned REF_HZ  = `SSU_REF_HZ
) (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       run_i,
  input  wire logic [3:0] lin_i,
  input  wire logic [3:0] exp_i,
  output logic            tick_o
);
  import ssu_pkg::*;

  // Both rates in megahertz units, so one reference cycle adds STEP base units.
  localparam logic [25:0] STEP = 26'(BASE_HZ / 1000000);
  localparam logic [25:0] UNIT = 26'(REF_HZ / 1000000);

  logic [25:0] half_base; // Half period in base-clock periods.
  logic [25:0] target;    // Half period in accumulator units.
  logic [25:0] sum;       // Accumulator after this cycle's step.
  logic [25:0] acc_q;     // Phase accumulator.
  logic        tick_q;    // Registered tick.

  // Half period is (lin + 1) * 2^exp base periods, giving the documented rate.
  always_comb begin
    half_base = 26'({1'b0, lin_i} + 5'h01) << exp_i;
    target    = 26'(half_base * UNIT);
    sum       = acc_q + STEP;
  end

  // Fractional accumulator; the base is faster than the reference clock, so the
  // fastest settings saturate at one tick per cycle rather than skipping ticks.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_q  <= 26'h0000000;
      tick_q <= 1'b0;
    end else if (!run_i) begin
      acc_q  <= 26'h0000000;
      tick_q <= 1'b0;
    end else if (sum >= target) begin
      acc_q  <= sum - target;
      tick_q <= 1'b1;
    end else begin
      acc_q  <= sum;
      tick_q <= 1'b0;
    end
  end

  assign tick_o = tick_q;

endmodule

//--- tb/ssu_props.sv
// Checker for the second serial unit: register port read data and event and interrupt pulses.
// Assumes it is bound onto the unit and sees only the unit's ports.
`timescale 1ns/1ps
module ssu_props (
  input wire logic              ref_clk_i,
  input wire logic              nrst_i,
  input wire ssu_pkg::ssu_req_s req_i,
  input wire logic [15:0]       rdata_o,
  input wire logic              top_irq_en_i,
  input wire logic              irq_o,
  input wire ssu_pkg::ssu_evt_s evt_o
);
  import ssu_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Read data stand only in the cycle after a read.
  chk_rdata_idle: assert property (!$past(req_i.rd) |-> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  chk_irq_top_mask: assert property (irq_o |-> $past(top_irq_en_i))
    else $error("interrupt while top mask closed");
  chk_irq_has_cause: assert property (irq_o |-> (|evt_o) || $past(|evt_o))
    else $error("interrupt without event");
  chk_cmd_pulse: assert property (evt_o.cmd_done |=> !evt_o.cmd_done)
    else $error("command event longer than one cycle");
  chk_nack_with_tx: assert property (evt_o.tx_nack |-> evt_o.tx_done)
    else $error("nack event without transmit event");
  chk_tx_pulse: assert property (evt_o.tx_done |=> !evt_o.tx_done)
    else $error("transmit event longer than one cycle");
  chk_rx_alone: assert property (evt_o.rx_done |-> !evt_o.tx_done && !evt_o.cmd_done)
    else $error("receive event beside another segment");
  chk_ovf_pulse: assert property (evt_o.rx_ovf |=> !evt_o.rx_ovf)
    else $error("overrun event longer than one cycle");
  chk_unf_pulse: assert property (evt_o.tx_unf |=> !evt_o.tx_unf)
    else $error("underrun event longer than one cycle");
  cover property (evt_o.cmd_done);
  cover property (evt_o.tx_nack);
  cover property (evt_o.rx_ovf);
endmodule

bind ssu_i2c_master ssu_props u_props (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req_i),
  .rdata_o(rdata_o), .top_irq_en_i(top_irq_en_i), .irq_o(irq_o), .evt_o(evt_o));

//--- tb/ssu_twi_slave.sv
// Two-wire slave model: takes written bytes and answers or refuses them, serves one byte on read.
// Assumes pulled-up lines resolved by the bench; it only ever pulls sda low.
`timescale 1ns/1ps
module ssu_twi_slave (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            sda_oe_o,
  output logic [7:0]      got_o,
  output logic            ack_o
);
  int slot = -1; // Bit slot of the byte, -1 just after a start.
  initial begin
    got_o = 8'h00;
    ack_o = 1'b0;
  end
  // A start restarts counting; each scl fall opens the next slot.
  // A data fall in the same step as an scl fall is no start, so scl is looked at just after.
  always @(negedge sda_i) #1 if (scl_i === 1'b1) slot = -1;
  always @(negedge scl_i) slot = (slot == 8) ? 0 : slot + 1;
  // Bits and the master's answer are taken while scl is high.
  always @(posedge scl_i) begin
    if (slot < 8) got_o = {got_o[6:0], sda_i};
    else ack_o = !sda_i;
  end
  // Data change only in low scl, so a served bit never fakes a start or stop.
  assign sda_oe_o = rd_i ? (slot >= 0 && slot < 8 && !tx_byte_i[7 - slot])
                         : (slot == 8 && !nack_i);
endmodule

//--- tb/testbench.sv
// Bench: register table, then two-wire segments against the slave model.
// Assumes the unit, its checker and the slave model are compiled first.
`timescale 1ns/1ps
`include "ssu_consts.svh"
module testbench;
  import ssu_pkg::*;
  typedef struct packed {logic [15:0] a, d, e;} ssu_row_s;
  logic            ref_clk_i, nrst_i, top_irq_en_i, scl_oe, sda_oe, slv_oe, nack, rdm, ack_s;
  logic            irq, sck, mosi;
  logic [7:0]      sbyte, got;
  logic [15:0]     rdata, v, q;
  ssu_req_s        req;
  ssu_evt_s        evt;
  int              n_errors, total_checks, irq_n, ev_n [6], ev_exp [6] = '{1, 1, 3, 3, 1, 1};
  real             dt, e;
  realtime         t_q [$];
  logic [15:0]     offs [8] = '{`SSU_DATA_OFF, `SSU_STAT_OFF, `SSU_CMD_OFF, `SSU_ACKC_OFF,
                                `SSU_MODE_OFF, `SSU_SPICFG_OFF, `SSU_RLIN_OFF, `SSU_REXP_OFF};
  ssu_row_s        rows [8] = '{'{`SSU_RLIN_OFF, 16'hfff3, 16'h0003},
    '{`SSU_REXP_OFF, 16'hfff1, 16'h0001}, '{`SSU_SPICFG_OFF, 16'h0027, 16'h0027},
    '{`SSU_IMASK_OFF, 16'h003f, 16'h003f}, '{`SSU_CMD_OFF, 16'h0004, 16'h0000},
    '{`SSU_ACKC_OFF, 16'hffff, 16'h0001}, '{`SSU_MODE_OFF, 16'hffff, 16'h0003},
    '{16'h4400, 16'h1234, 16'h0000}};
  // Pulled-up open-drain lines: low while any party pulls.
  wire scl = !scl_oe;
  wire sda = !(sda_oe | slv_oe);
  ssu_i2c_master DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
    .top_irq_en_i(top_irq_en_i), .irq_o(irq), .evt_o(evt), .scl_i(scl), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .spi_sck_o(sck),
    .spi_mosi_o(mosi), .spi_miso_i(mosi));
  ssu_twi_slave u_slv (.scl_i(scl), .sda_i(sda), .nack_i(nack), .rd_i(rdm),
    .tx_byte_i(sbyte), .sda_oe_o(slv_oe), .got_o(got), .ack_o(ack_s));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Event pulses and interrupts are counted where they stand.
  always @(posedge ref_clk_i) begin
    for (int i = 0; i < 6; i++) if (evt[i] === 1'b1) ev_n[i]++;
    if (irq === 1'b1) irq_n++;
  end
  always @(posedge scl) t_q.push_back($realtime);
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] ex, sn);
    total_checks++;
    if (sn !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, ex, sn);
    end
  endtask
  // Strobes are one cycle; the idle cycle after each keeps one assignment per step.
  task automatic wr(input logic [15:0] a, d);
    @(posedge ref_clk_i) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i) req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk_i) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i) req <= '0;
    @(posedge ref_clk_i) d = rdata;
  endtask
  // Issue a command, poll until its bit clears, then compare the masked status.
  task automatic seg(input logic [15:0] c, st, m);
    v = 16'hffff;
    wr(`SSU_CMD_OFF, c);
    for (int k = 0; k < 300 && v !== 16'h0000; k++) rd(`SSU_CMD_OFF, v);
    chk("command bit", 16'h0000, v);
    if (v !== 16'h0000) conclude();
    rd(`SSU_STAT_OFF, v);
    chk("status", st, v & m);
  endtask
  initial begin
    nrst_i = 1'b0;
    top_irq_en_i = 1'b1;
    req = '0;
    {nack, rdm, sbyte} = '0;
    repeat (2) @(posedge ref_clk_i);
    chk("outputs in reset", 16'h0000, {13'h0000, scl_oe, sda_oe, irq});
    nrst_i <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i], v);
      chk("reset value", 16'h0000, v);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk("register", rows[i].e, v);
    end
    seg(16'h0004, 16'h0008, 16'hffff);
    chk("start interrupt", 16'h0001, irq_n[15:0]);
    wr(`SSU_DATA_OFF, 16'h00a5);
    seg(16'h0002, 16'h0002, 16'hffff);
    chk("slave byte", 16'h00a5, {8'h00, got});
    dt = t_q[$] - t_q[$-8];
    e = 16.0 * 4 * 2 * 1.0e9 / `SSU_BASE_HZ;
    chk("rate", 16'h0001, {15'h0000, dt > 0.92 * e && dt < 1.08 * e});
    wr(`SSU_DATA_OFF, 16'h003c);
    nack = 1'b1;
    seg(16'h0002, 16'h0003, 16'hffff);
    {nack, rdm, sbyte} = {2'b01, 8'h96};
    seg(16'h0001, 16'h0004, 16'hffff);
    chk("master ack", 16'h0001, {15'h0000, ack_s});
    rd(`SSU_DATA_OFF, v);
    chk("received byte", 16'h0096, v);
    wr(`SSU_ACKC_OFF, 16'h0000);
    sbyte = 8'h69;
    seg(16'h0001, 16'h0004, 16'h000e);
    chk("master nack", 16'h0000, {15'h0000, ack_s});
    seg(16'h0001, 16'h0004, 16'h000e);
    rd(`SSU_DATA_OFF, v);
    chk("kept byte", 16'h0069, v);
    rdm = 1'b0;
    seg(16'h0002, 16'h0002, 16'hffff);
    chk("idle byte", 16'h00ff, {8'h00, got});
    foreach (ev_exp[i]) chk("event count", ev_exp[i][15:0], ev_n[i][15:0]);
    q = irq_n[15:0];
    top_irq_en_i <= 1'b0;
    seg(16'h0008, 16'h0008, 16'hffff);
    chk("masked interrupt", q, irq_n[15:0]);
    // SPI byte looped back from data out to data in: idle clock level, then the byte.
    wr(`SSU_MODE_OFF, 16'h0000);
    wr(`SSU_DATA_OFF, 16'h005a);
    chk("spi clock idle", 16'h0001, {15'h0000, sck});
    wr(`SSU_MODE_OFF, 16'h0002);
    repeat (160) @(posedge ref_clk_i);
    rd(`SSU_DATA_OFF, v);
    chk("spi loopback", 16'h005a, v);
    conclude();
  end
  initial begin
    #3ms;
    n_errors++;
    conclude();
  end
endmodule
